// ### design/seen_axis_clamp.sv
// Range limiter for one lateral axis
`timescale 1ns/1ps
module seen_axis_clamp #(
  parameter logic [15:0] LIMIT_HS = seen_pkg::LIMIT_HIGH_SENS,
  parameter logic [15:0] LIMIT_WR = seen_pkg::LIMIT_WIDE
) (
  input wire logic signed [15:0] raw,
  input wire logic wide_range,
  output logic signed [15:0] clamped,
  output logic overflow
);
  logic signed [15:0] limit;

  // Limit follows the range setting; both stay positive codes
  assign limit = wide_range ? $signed(LIMIT_WR) : $signed(LIMIT_HS);

  // Fixed limit value replaces any reading beyond it
  always_comb begin
    overflow = 1'b0;
    clamped = raw;
    if (raw > limit) begin
      overflow = 1'b1;
      clamped = limit;
    end else if (raw < -limit) begin
      overflow = 1'b1;
      clamped = -limit;
    end
  end
endmodule : seen_axis_clamp

// ### design/seen_pkg.sv
// Shared constants of the sensor error and event notifier
package seen_pkg;

  // ************************************************
  // Register bus widths and address map
  // ************************************************
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int SW_N = 6;
  localparam logic [6:0] ADDR_STATUS = 7'h10;
  localparam logic [6:0] ADDR_X_HI = 7'h11;
  localparam logic [6:0] ADDR_X_LO = 7'h12;
  localparam logic [6:0] ADDR_Y_HI = 7'h13;
  localparam logic [6:0] ADDR_Y_LO = 7'h14;
  localparam logic [6:0] ADDR_Z_HI = 7'h15;
  localparam logic [6:0] ADDR_Z_LO = 7'h16;
  localparam logic [6:0] ADDR_SWITCH = 7'h17;
  localparam logic [6:0] ADDR_READ_LO = 7'h10;
  localparam logic [6:0] ADDR_READ_HI = 7'h1f;
  localparam logic [6:0] ADDR_CTRL = 7'h20;
  localparam logic [6:0] ADDR_SW_EN = 7'h21;
  localparam logic [6:0] ADDR_SET_LO = 7'h20;
  localparam logic [6:0] ADDR_SET_HI = 7'h27;
  localparam logic [6:0] ADDR_IRQ_STS = 7'h30;
  localparam logic [6:0] ADDR_IRQ_CLR = 7'h31;
  localparam logic [6:0] ADDR_IRQ_EN = 7'h32;

  // ************************************************
  // Field positions
  // ************************************************
  localparam int ST_READY = 0;
  localparam int ST_RANGE = 1;
  localparam int ST_CONV = 2;
  localparam int CT_READY_EN = 0;
  localparam int CT_RANGE_EN = 1;
  localparam int CT_CONV_EN = 2;
  localparam int CT_PP_EN = 3;
  localparam int CT_OD_EN = 4;
  localparam int EV_READY = 0;
  localparam int EV_RANGE = 1;
  localparam int EV_CONV = 2;
  localparam int EV_SWITCH = 3;
  localparam int EV_N = 4;

  // ************************************************
  // Reset values and clamp limits in result codes
  // ************************************************
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [5:0] SW_EN_RST = 6'h00;
  localparam logic [15:0] LIMIT_HIGH_SENS = 16'h7ffc;
  localparam logic [15:0] LIMIT_WIDE = 16'h2bfd;

endpackage : seen_pkg

// ### design/seen_sw_if.sv
// Signals between the notifier core and one switch comparator
`timescale 1ns/1ps
interface seen_sw_if;
  logic signed [15:0] sample;
  logic signed [15:0] bop;
  logic signed [15:0] brp;
  logic prev;
  logic next;
  modport core (output sample, output bop, output brp, output prev, input next);
  modport cmp (input sample, input bop, input brp, input prev, output next);
endinterface : seen_sw_if

// ### design/seen_switch_cmp.sv
// One hysteresis comparator of the programmable switch
`timescale 1ns/1ps
module seen_switch_cmp (
  seen_sw_if.cmp sw
);
  // Disabled when operate is not above release: keep old state
  always_comb begin
    sw.next = sw.prev;
    if (sw.bop > sw.brp) begin
      if (sw.sample > sw.bop) begin
        sw.next = 1'b1;
      end else if (sw.sample < sw.brp) begin
        sw.next = 1'b0;
      end
    end
  end
endmodule : seen_switch_cmp

// ### design/seen_top.sv
// Error flags, switch states and event pins of the magnetic sensor
// How it works
// RQ1 - Overrange X/Y reads out the fixed limit
// RQ2 - Any X/Y overrange sets range overflow flag
// RQ3 - Back in range, results and flag refresh
// RQ4 - Converter overrange sets converter overflow flag
// RQ5 - Converter flag refreshed with every result update
// RQ6 - Separate enables for push-pull and open-drain pins
// RQ7 - Active event: push-pull high, open-drain low
// RQ8 - Four gated sources ORed onto the pins
// RQ9 - Six switch enables, change either way
// RQ10 - No enabled event: pins stay inactive
// RQ11 - Read 10h-1Fh or write 20h-27h releases pins
// RQ12 - Pins assert at end of measurement
// RQ13 - Ready set on store, cleared by reads
// RQ14 - Switch bit follows operate/release thresholds
// RQ15 - Host reads status and results to service
`timescale 1ns/1ps
module seen_top #(
  parameter logic [15:0] LIMIT_HS = seen_pkg::LIMIT_HIGH_SENS,
  parameter logic [15:0] LIMIT_WR = seen_pkg::LIMIT_WIDE
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic meas_done,
  input wire logic signed [15:0] raw_x,
  input wire logic signed [15:0] raw_y,
  input wire logic signed [15:0] raw_z,
  input wire logic adc_overflow,
  input wire logic wide_range,
  input wire logic [seen_pkg::SW_N-1:0][15:0] bop_thr,
  input wire logic [seen_pkg::SW_N-1:0][15:0] brp_thr,
  input wire logic [seen_pkg::ADDR_W-1:0] addr,
  input wire logic [seen_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [seen_pkg::DATA_W-1:0] rdata,
  output logic push_pull_event_pin,
  output logic open_drain_event_pin_out,
  output logic open_drain_event_pin_oe,
  output logic irq
);

  // ************************************************
  // Declarations
  // ************************************************
  logic signed [15:0] x_field_result, y_field_result, z_field_result;
  logic signed [15:0] x_clamped, y_clamped;
  logic x_ovf, y_ovf;
  logic data_ready_flag;
  logic xy_range_overflow_flag;
  logic converter_overflow_flag;
  logic [seen_pkg::SW_N-1:0] switch_state_bits;
  logic [seen_pkg::SW_N-1:0] sw_next;
  logic [7:0] ctrl_reg;
  logic [seen_pkg::SW_N-1:0] sw_en_reg;
  logic pending_reg;
  logic pending_next;
  logic [seen_pkg::EV_N-1:0] irq_sts_reg;
  logic [seen_pkg::EV_N-1:0] irq_en_reg;
  logic [seen_pkg::EV_N-1:0] irq_set;
  logic [7:0] rdata_next;
  logic rd_result, wr_setting, set_access, read_done, release_pins;
  logic sw_change, event_cond;
  logic push_pull_event_enable, open_drain_event_enable;
  logic ready_event_enable, range_overflow_event_enable, converter_overflow_event_enable;

  // ************************************************
  // Range limiting and switch comparators
  // ************************************************
  // RQ1 clamp X axis
  seen_axis_clamp #(.LIMIT_HS(LIMIT_HS), .LIMIT_WR(LIMIT_WR)) u_clamp_x (
    .raw(raw_x),
    .wide_range(wide_range),
    .clamped(x_clamped),
    .overflow(x_ovf)
  );

  // RQ1 clamp Y axis
  seen_axis_clamp #(.LIMIT_HS(LIMIT_HS), .LIMIT_WR(LIMIT_WR)) u_clamp_y (
    .raw(raw_y),
    .wide_range(wide_range),
    .clamped(y_clamped),
    .overflow(y_ovf)
  );

  seen_sw_if sw_if[seen_pkg::SW_N] ();

  // Comparators in order x1, x2, y1, y2, z1, z2
  for (genvar i = 0; i < seen_pkg::SW_N; i++) begin : g_sw
    assign sw_if[i].sample = (i < 2) ? x_clamped : (i < 4) ? y_clamped : raw_z;
    assign sw_if[i].bop = $signed(bop_thr[i]);
    assign sw_if[i].brp = $signed(brp_thr[i]);
    assign sw_if[i].prev = switch_state_bits[i];
    assign sw_next[i] = sw_if[i].next;
    // RQ14 hysteresis compare
    seen_switch_cmp u_cmp (
      .sw(sw_if[i])
    );
  end

  // ************************************************
  // Access decode
  // ************************************************
  // Reads of the result window and writes of the setting window
  assign rd_result = rd && (addr >= seen_pkg::ADDR_READ_LO) && (addr <= seen_pkg::ADDR_READ_HI);
  assign wr_setting = wr && (addr >= seen_pkg::ADDR_SET_LO) && (addr <= seen_pkg::ADDR_SET_HI);
  assign set_access = (rd || wr) && (addr >= seen_pkg::ADDR_SET_LO)
    && (addr <= seen_pkg::ADDR_SET_HI);
  // Last byte of any axis ends a read-through
  assign read_done = rd && ((addr == seen_pkg::ADDR_X_LO) || (addr == seen_pkg::ADDR_Y_LO)
    || (addr == seen_pkg::ADDR_Z_LO));
  assign release_pins = rd_result || wr_setting;

  assign push_pull_event_enable = ctrl_reg[seen_pkg::CT_PP_EN];
  assign open_drain_event_enable = ctrl_reg[seen_pkg::CT_OD_EN];
  assign ready_event_enable = ctrl_reg[seen_pkg::CT_READY_EN];
  assign range_overflow_event_enable = ctrl_reg[seen_pkg::CT_RANGE_EN];
  assign converter_overflow_event_enable = ctrl_reg[seen_pkg::CT_CONV_EN];

  // ************************************************
  // Measurement results and error flags
  // ************************************************
  // RQ3 results refresh every measurement
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      x_field_result <= 16'sh0000;
      y_field_result <= 16'sh0000;
      z_field_result <= 16'sh0000;
    end else if (ce && meas_done) begin
      x_field_result <= x_clamped;
      y_field_result <= y_clamped;
      z_field_result <= raw_z;
    end
  end

  // RQ2 range flag from this measurement
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      xy_range_overflow_flag <= 1'b0;
    end else if (ce && meas_done) begin
      xy_range_overflow_flag <= x_ovf || y_ovf;
    end
  end

  // RQ4 RQ5 converter flag with results
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      converter_overflow_flag <= 1'b0;
    end else if (ce && meas_done) begin
      converter_overflow_flag <= adc_overflow;
    end
  end

  // RQ14 switch states stored on update
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      switch_state_bits <= '0;
    end else if (ce && meas_done) begin
      switch_state_bits <= sw_next;
    end
  end

  // RQ13 ready set wins over a read clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      data_ready_flag <= 1'b0;
    end else if (ce) begin
      if (meas_done) begin
        data_ready_flag <= 1'b1;
      end else if (read_done || set_access) begin
        data_ready_flag <= 1'b0;
      end
    end
  end

  // ************************************************
  // Event pins
  // ************************************************
  // RQ9 any enabled comparator flipping either way
  assign sw_change = |((sw_next ^ switch_state_bits) & sw_en_reg);

  // RQ8 OR of gated sources for this measurement
  always_comb begin
    event_cond = ready_event_enable
      || (range_overflow_event_enable && (x_ovf || y_ovf))
      || (converter_overflow_event_enable && adc_overflow)
      || sw_change;
  end

  // RQ12 RQ11 set at measurement end, released by access
  always_comb begin
    pending_next = pending_reg;
    if (meas_done && event_cond) begin
      pending_next = 1'b1;
    end else if (release_pins) begin
      pending_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pending_reg <= 1'b0;
    end else if (ce) begin
      pending_reg <= pending_next;
    end
  end

  // RQ6 RQ7 RQ10 each pin gated by its own enable
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      push_pull_event_pin <= 1'b0;
      open_drain_event_pin_oe <= 1'b0;
      open_drain_event_pin_out <= 1'b0;
    end else if (ce) begin
      push_pull_event_pin <= pending_next && push_pull_event_enable;
      open_drain_event_pin_oe <= pending_next && open_drain_event_enable;
      open_drain_event_pin_out <= 1'b0;
    end
  end

  // ************************************************
  // Setting registers
  // ************************************************
  // Control and switch enables; writes elsewhere are dropped
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_reg <= seen_pkg::CTRL_RST;
      sw_en_reg <= seen_pkg::SW_EN_RST;
    end else if (ce && wr) begin
      if (addr == seen_pkg::ADDR_CTRL) begin
        ctrl_reg <= wdata;
      end
      if (addr == seen_pkg::ADDR_SW_EN) begin
        sw_en_reg <= wdata[seen_pkg::SW_N-1:0];
      end
    end
  end

  // ************************************************
  // Interrupt status, enable and clear
  // ************************************************
  // Events of this measurement, before the interrupt enables; switch changes already masked by sw_en_reg
  always_comb begin
    irq_set = '0;
    irq_set[seen_pkg::EV_READY] = meas_done;
    irq_set[seen_pkg::EV_RANGE] = meas_done && (x_ovf || y_ovf);
    irq_set[seen_pkg::EV_CONV] = meas_done && adc_overflow;
    irq_set[seen_pkg::EV_SWITCH] = meas_done && sw_change;
  end

  // Sticky bits; a new event beats a same-cycle clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq_sts_reg <= '0;
    end else if (ce) begin
      if (wr && (addr == seen_pkg::ADDR_IRQ_CLR)) begin
        irq_sts_reg <= (irq_sts_reg & ~wdata[seen_pkg::EV_N-1:0]) | irq_set;
      end else begin
        irq_sts_reg <= irq_sts_reg | irq_set;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq_en_reg <= '0;
    end else if (ce && wr && (addr == seen_pkg::ADDR_IRQ_EN)) begin
      irq_en_reg <= wdata[seen_pkg::EV_N-1:0];
    end
  end

  // Level output from the registered status
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(irq_sts_reg & irq_en_reg);
    end
  end

  // ************************************************
  // Read data
  // ************************************************
  // Unmapped and write-only addresses read zero
  always_comb begin
    rdata_next = 8'h00;
    unique case (addr)
      seen_pkg::ADDR_STATUS: begin
        rdata_next[seen_pkg::ST_READY] = data_ready_flag;
        rdata_next[seen_pkg::ST_RANGE] = xy_range_overflow_flag;
        rdata_next[seen_pkg::ST_CONV] = converter_overflow_flag;
      end
      seen_pkg::ADDR_X_HI: rdata_next = x_field_result[15:8];
      seen_pkg::ADDR_X_LO: rdata_next = x_field_result[7:0];
      seen_pkg::ADDR_Y_HI: rdata_next = y_field_result[15:8];
      seen_pkg::ADDR_Y_LO: rdata_next = y_field_result[7:0];
      seen_pkg::ADDR_Z_HI: rdata_next = z_field_result[15:8];
      seen_pkg::ADDR_Z_LO: rdata_next = z_field_result[7:0];
      seen_pkg::ADDR_SWITCH: rdata_next = {2'b00, switch_state_bits};
      seen_pkg::ADDR_CTRL: rdata_next = ctrl_reg;
      seen_pkg::ADDR_SW_EN: rdata_next = {2'b00, sw_en_reg};
      seen_pkg::ADDR_IRQ_STS: rdata_next = {4'h0, irq_sts_reg};
      seen_pkg::ADDR_IRQ_EN: rdata_next = {4'h0, irq_en_reg};
      default: rdata_next = 8'h00;
    endcase
  end

  // Data stand for one cycle after the strobe only
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (ce) begin
      rdata <= rd ? rdata_next : 8'h00;
    end
  end

  // ************************************************
  // Checks
  // ************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  clamp_value_a: assert property (ce && meas_done && x_ovf |=> // RQ1
    (x_field_result == $signed($past(wide_range) ? LIMIT_WR : LIMIT_HS)) ||
    (x_field_result == -$signed($past(wide_range) ? LIMIT_WR : LIMIT_HS)))
    else $error("x result not at limit after overrange");
  range_flag_set_a: assert property (ce && meas_done && (x_ovf || y_ovf) // RQ2
    |=> xy_range_overflow_flag)
    else $error("range flag not set on overrange");
  result_refresh_a: assert property (ce && meas_done && !y_ovf // RQ3
    |=> y_field_result == $past(raw_y) && !xy_range_overflow_flag == !$past(x_ovf))
    else $error("y result or range flag not refreshed");
  conv_flag_a: assert property (ce && meas_done // RQ5
    |=> converter_overflow_flag == $past(adc_overflow))
    else $error("converter flag not refreshed");
  pin_enable_a: assert property (ce && !push_pull_event_enable // RQ6
    |=> !push_pull_event_pin)
    else $error("push-pull pin high while disabled");
  pin_assert_a: assert property (ce && meas_done && ready_event_enable // RQ12
    && push_pull_event_enable && open_drain_event_enable
    |=> push_pull_event_pin && open_drain_event_pin_oe && !open_drain_event_pin_out)
    else $error("pins not asserted at measurement end");
  pin_release_a: assert property (ce && release_pins && !meas_done // RQ11
    |=> !push_pull_event_pin && !open_drain_event_pin_oe)
    else $error("pins not released by access");
  idle_low_a: assert property (ce && !pending_next // RQ10
    |=> !push_pull_event_pin && !open_drain_event_pin_oe)
    else $error("pin active without event");
  ready_flag_a: assert property (ce && meas_done |=> data_ready_flag) // RQ13
    else $error("ready flag not set on store");
  ready_clear_a: assert property (ce && (read_done || set_access) && !meas_done // RQ13
    |=> !data_ready_flag)
    else $error("ready flag not cleared by read");
  switch_event_a: assert property (ce && meas_done && sw_change // RQ9
    && push_pull_event_enable |=> push_pull_event_pin)
    else $error("switch change did not raise pin");

endmodule : seen_top

// ### tb/seen_host_model.sv
// Host processor model: register bus master and event pin monitor
`timescale 1ns/1ps
module seen_host_model (
  input wire logic clk_sys,
  output logic [seen_pkg::ADDR_W-1:0] addr,
  output logic [seen_pkg::DATA_W-1:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [seen_pkg::DATA_W-1:0] rdata,
  input wire logic od_out,
  input wire logic od_oe,
  output logic od_level
);
  // ************************************************
  // Pin and bus idle state
  // ************************************************
  // pull-up on pin
  // Board pull-up: the wire is high unless the device sinks it
  assign od_level = od_oe ? od_out : 1'b1;

  // Bus idle from time zero so no strobe is ever unknown
  initial begin
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
  end

  // ************************************************
  // Bus cycles
  // ************************************************
  // One-cycle write strobe beside address and data
  task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    #1;
  endtask : write_reg

  // host services events
  // Read strobe for one cycle, data taken in the cycle after it
  task automatic read_reg(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : read_reg
endmodule : seen_host_model

// ### tb/tb_top.sv
// Self-checking bench of the sensor error and event notifier
`timescale 1ns/1ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin error_cnt++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic meas_done = 1'b0;
  logic signed [15:0] raw_x = '0;
  logic signed [15:0] raw_y = '0;
  logic signed [15:0] raw_z = '0;
  logic adc_overflow = 1'b0;
  logic wide_range = 1'b0;
  logic [seen_pkg::SW_N-1:0][15:0] bop_thr = '0;
  logic [seen_pkg::SW_N-1:0][15:0] brp_thr = '0;
  logic [seen_pkg::ADDR_W-1:0] addr;
  logic [seen_pkg::DATA_W-1:0] wdata;
  logic [seen_pkg::DATA_W-1:0] rdata;
  logic wr, rd, pp_pin, od_out, od_oe, od_level, irq, w;
  int error_cnt = 0;
  int cmp_count = 0;
  logic [31:0] seed = 32'h0d4d;
  logic [7:0] rv;
  logic [15:0] r16;
  logic signed [15:0] vx, vy, vz;

  // 50 MHz system clock
  always #10 clk_sys = ~clk_sys;

  seen_top seen_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .meas_done(meas_done),
    .raw_x(raw_x), .raw_y(raw_y), .raw_z(raw_z), .adc_overflow(adc_overflow),
    .wide_range(wide_range), .bop_thr(bop_thr), .brp_thr(brp_thr), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .push_pull_event_pin(pp_pin),
    .open_drain_event_pin_out(od_out), .open_drain_event_pin_oe(od_oe), .irq(irq));

  seen_host_model seen_host_model_i (.clk_sys(clk_sys), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .od_out(od_out), .od_oe(od_oe), .od_level(od_level));

  // ************************************************
  // Helpers
  // ************************************************
  // In-range random code, kept well inside both limits
  function automatic logic [15:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return {{3{seed[12]}}, seed[12:0]};
  endfunction : rnd

  // Expected stored lateral result after range limiting
  function automatic logic [15:0] clamp_exp(input logic signed [15:0] v, input logic wd);
    logic signed [16:0] lim;
    lim = wd ? {1'b0, seen_pkg::LIMIT_WIDE} : {1'b0, seen_pkg::LIMIT_HIGH_SENS};
    if (v > lim) return lim[15:0];
    if (v < -lim) return 16'(-lim);
    return v;
  endfunction : clamp_exp

  task automatic measure(input logic [15:0] x, y, z, input logic ovf, input logic wd);
    @(posedge clk_sys);
    raw_x <= x;
    raw_y <= y;
    raw_z <= z;
    adc_overflow <= ovf;
    wide_range <= wd;
    meas_done <= 1'b1;
    @(posedge clk_sys);
    meas_done <= 1'b0;
    #1;
  endtask : measure

  task automatic wreg(input logic [6:0] a, input logic [7:0] d);
    seen_host_model_i.write_reg(a, d);
  endtask : wreg

  task automatic rd8(input logic [6:0] a);
    seen_host_model_i.read_reg(a, rv);
  endtask : rd8

  // High byte first; the low byte ends a read-through
  task automatic rd16(input logic [6:0] a);
    seen_host_model_i.read_reg(a, r16[15:8]);
    seen_host_model_i.read_reg(a + 7'h01, r16[7:0]);
  endtask : rd16

  task automatic pins(input logic pp_exp, input logic od_exp);
    `CHK(pp_pin, pp_exp)
    `CHK(od_level, od_exp)
  endtask : pins

  task automatic irq_after_edge(input logic exp);
    @(posedge clk_sys);
    #1;
    `CHK(irq, exp)
  endtask : irq_after_edge

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    #200000;
    error_cnt++;
    finish_test();
  end

  // ************************************************
  // Main sequence
  // ************************************************
  initial begin
    @(posedge clk_sys);
    bop_thr[0] <= 16'h0064;
    brp_thr[0] <= 16'h0032;
    @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    pins(1'b0, 1'b1);
    rd8(seen_pkg::ADDR_CTRL);
    `CHK(rv, seen_pkg::CTRL_RST)
    // Random in-range data, ready event on both pins, full service each time
    wreg(seen_pkg::ADDR_CTRL, 8'h19);
    for (int i = 0; i < 8; i++) begin
      vx = rnd();
      vy = rnd();
      vz = rnd();
      w = seed[20];
      measure(vx, vy, vz, 1'b0, w);
      pins(1'b1, 1'b0);
      rd8(seen_pkg::ADDR_STATUS);
      `CHK(rv[2:0], 3'b001)
      pins(1'b0, 1'b1);
      rd16(seen_pkg::ADDR_X_HI);
      `CHK(r16, clamp_exp(vx, w))
      rd16(seen_pkg::ADDR_Y_HI);
      `CHK(r16, clamp_exp(vy, w))
      rd16(seen_pkg::ADDR_Z_HI);
      `CHK(r16, vz)
      rd8(seen_pkg::ADDR_STATUS);
      `CHK(rv[2:0], 3'b000)
    end
    // Lateral overrange in both range settings, then back in range
    wreg(seen_pkg::ADDR_CTRL, 8'h1a);
    measure(16'h7fff, 16'h0000, 16'h0000, 1'b0, 1'b0);
    pins(1'b1, 1'b0);
    rd8(seen_pkg::ADDR_STATUS);
    `CHK(rv[2:0], 3'b011)
    rd16(seen_pkg::ADDR_X_HI);
    `CHK(r16, seen_pkg::LIMIT_HIGH_SENS)
    measure(16'h0000, 16'h3000, 16'h0000, 1'b0, 1'b1);
    rd16(seen_pkg::ADDR_Y_HI);
    `CHK(r16, seen_pkg::LIMIT_WIDE)
    measure(16'h0005, 16'h0000, 16'h0000, 1'b0, 1'b0);
    pins(1'b0, 1'b1);
    rd8(seen_pkg::ADDR_STATUS);
    `CHK(rv[2:0], 3'b001)
    rd16(seen_pkg::ADDR_X_HI);
    `CHK(r16, 16'h0005)
    // Converter overrange on the push-pull pin only, refreshed next time
    wreg(seen_pkg::ADDR_CTRL, 8'h0c);
    measure(16'h0001, 16'h0002, 16'h0003, 1'b1, 1'b0);
    pins(1'b1, 1'b1);
    rd8(seen_pkg::ADDR_STATUS);
    `CHK(rv[2:0], 3'b101)
    measure(16'h0001, 16'h0002, 16'h0003, 1'b0, 1'b0);
    pins(1'b0, 1'b1);
    rd8(seen_pkg::ADDR_STATUS);
    `CHK(rv[2:0], 3'b001)
    wreg(7'h22, 8'h00);
    rd8(seen_pkg::ADDR_STATUS);
    `CHK(rv[2:0], 3'b000)
    // Pins disabled; event seen through the interrupt registers instead
    wreg(seen_pkg::ADDR_IRQ_CLR, 8'h0f);
    wreg(seen_pkg::ADDR_IRQ_EN, 8'h01);
    wreg(seen_pkg::ADDR_CTRL, 8'h01);
    measure(16'h0000, 16'h0000, 16'h0000, 1'b0, 1'b0);
    pins(1'b0, 1'b1);
    irq_after_edge(1'b1);
    rd8(seen_pkg::ADDR_IRQ_STS);
    `CHK(rv[3:0], 4'b0001)
    wreg(seen_pkg::ADDR_IRQ_EN, 8'h00);
    irq_after_edge(1'b0);
    wreg(seen_pkg::ADDR_IRQ_EN, 8'h01);
    irq_after_edge(1'b1);
    wreg(seen_pkg::ADDR_IRQ_CLR, 8'h01);
    irq_after_edge(1'b0);
    rd8(seen_pkg::ADDR_IRQ_STS);
    `CHK(rv[3:0], 4'b0000)
    // Switch on first X comparator, both directions and inside the hysteresis
    wreg(seen_pkg::ADDR_CTRL, 8'h08);
    wreg(seen_pkg::ADDR_SW_EN, 8'h01);
    measure(16'h00c8, 16'h0000, 16'h0000, 1'b0, 1'b0);
    pins(1'b1, 1'b1);
    rd8(7'h40);
    `CHK(rv, 8'h00)
    pins(1'b1, 1'b1);
    rd8(seen_pkg::ADDR_SWITCH);
    `CHK(rv[0], 1'b1)
    measure(16'h004b, 16'h0000, 16'h0000, 1'b0, 1'b0);
    pins(1'b0, 1'b1);
    rd8(seen_pkg::ADDR_SWITCH);
    `CHK(rv[0], 1'b1)
    measure(16'h000a, 16'h0000, 16'h0000, 1'b0, 1'b0);
    pins(1'b1, 1'b1);
    rd8(seen_pkg::ADDR_SWITCH);
    `CHK(rv[0], 1'b0)
    wreg(seen_pkg::ADDR_SW_EN, 8'h00);
    measure(16'h00c8, 16'h0000, 16'h0000, 1'b0, 1'b0);
    pins(1'b0, 1'b1);
    // Clock enable low: the strobe and its overflow must be ignored
    @(posedge clk_sys);
    ce <= 1'b0;
    measure(16'h0005, 16'h0000, 16'h0000, 1'b1, 1'b0);
    @(posedge clk_sys);
    ce <= 1'b1;
    rd8(seen_pkg::ADDR_STATUS);
    `CHK(rv[2:0], 3'b001)
    rd16(seen_pkg::ADDR_X_HI);
    `CHK(r16, 16'h00c8)
    finish_test();
  end
endmodule : tb_top
